//--- core/cdc_sync.sv
// two-flop synchroniser for a group of independent levels
// assumes each bit is a slow level or a toggle
`timescale 1ns/1ps
`default_nettype none
module cdc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // levels
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;
  sync_s r, r_nxt;

  // first stage feeds only the second
  always_comb begin
    r_nxt = r;
    r_nxt.s1 = i_d;
    r_nxt.s2 = r.s1;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign o_q = r.s2;
endmodule // cdc_sync
`default_nettype wire

//--- core/flash_regs_pkg.sv
// constants and types shared by the flash/regulator register bank
// assumes a 200 MHz core clock
package flash_regs_pkg;
  // register addresses and reset values
  localparam logic [7:0] SINK_CONTROL_ADDR = 8'h02;
  localparam logic [7:0] SINK_CONTROL_RESET = 8'h10;
  localparam logic [7:0] REGULATOR_CONTROL_ADDR = 8'h03;
  localparam logic [7:0] REGULATOR_CONTROL_RESET = 8'h00;
  // link slave address, 7-bit
  localparam logic [6:0] SLAVE_ADDR = 7'h37;
  // field positions
  localparam int TIMEOUT_EN_BIT = 4;
  localparam int CODE_LSB = 1;
  localparam int RANGE_BIT = 0;
  localparam int REG_B_LSB = 4;
  localparam int REG_A_LSB = 0;
  // safety timer
  localparam int TIMEOUT_S = 1;
  localparam int CLK_HZ = 200_000_000;
  localparam int TIMEOUT_CYCLES = TIMEOUT_S * CLK_HZ;
  // sink currents in mA
  localparam logic [8:0] CUR_STEP_MA = 9'h032;
  localparam logic [8:0] SPOT_MAX_MA = 9'h0fa;
  localparam logic [8:0] FLASH_LOW_MA = 9'h12c;
  localparam logic [8:0] FLASH_MID_MA = 9'h15e;
  localparam logic [8:0] FLASH_MAX_MA = 9'h190;
  // regulator voltages in mV
  localparam logic [11:0] REG_A_TOP_MV = 12'hce4;
  localparam logic [11:0] REG_B_TOP_MV = 12'h708;
  localparam logic [11:0] REG_STEP_MV = 12'h064;
  localparam logic [3:0] REG_A_MAX_CODE = 4'h9;
  localparam logic [2:0] REG_B_MAX_CODE = 3'h4;
  // link engine states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_REG, ST_WR, ST_ACK, ST_RD, ST_MACK
  } link_st_e;
endpackage

//--- core/flash_regulator_control_regs.sv
// flash sink and regulator control registers behind a two-wire serial slave
// assumes i_link_clk oversamples scl/sda; pins are open drain, wired outside
// How it works
// - sink control register at 0x02, reset value 0x10.
// - bit 4 of sink control enables the safety timer, default on.
// - with timer on, sink turns off after 1 s active until re-armed.
// - trigger pin low re-arms after a timeout.
// - writing code zero then nonzero re-arms after a timeout.
// - spotlight range codes: off, 50-200 mA steps, then 250 mA.
// - flash range codes: off, 300, 350, then 400 mA.
// - bit 0 picks flash range when set, spotlight when clear.
// - regulator control register at 0x03, reset value 0x00.
// - bits 6-4 give regulator B: off, 1.8 down to 1.5 V, else off.
// - bits 3-0 give regulator A: off, 3.3 down to 2.5 V.
// - read-write serial slave with 8-bit registers.
// - direct writes; combined and stop-separated reads keep the pointer.
// - pointer never increments; each access sends an address.
// - start and stop frame transfers; repeated start accepted.
// - slave address 0110111, 0x6e write, 0x6f read.
// - 7-bit addressing only, 100 or 400 kbit/s.
// - registers held at defaults while chip enable is low.
// - trigger pin high starts the sink; tied high means software control.
`timescale 1ns/1ps
`default_nettype none
module flash_regulator_control_regs #(
  parameter int TIMEOUT_CYCLES = flash_regs_pkg::TIMEOUT_CYCLES
) (
  // core clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // link clock
  input wire logic i_link_clk,
  // serial pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // device pins
  input wire logic i_chip_enable,
  input wire logic i_flash_trigger_pin,
  // sink
  output logic o_sink_on,
  output logic [8:0] o_sink_current_ma,
  output logic o_safety_timed_out,
  // regulators
  output logic [11:0] o_regulator_a_mv,
  output logic [11:0] o_regulator_b_mv,
  // register contents
  output logic [7:0] o_sink_control,
  output logic [7:0] o_regulator_control
);
  // ---- resets, released through two flops per domain
  logic rstn_core;
  logic rstn_link;

  cdc_sync #(.W(1)) u_rst_core (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(1'b1),
    .o_q(rstn_core)
  );

  cdc_sync #(.W(1)) u_rst_link (
    .i_clk(i_link_clk),
    .i_rstn(i_rstn),
    .i_d(1'b1),
    .o_q(rstn_link)
  );

  // ---- link domain
  typedef struct packed {
    logic scl_d;
    logic sda_d;
    flash_regs_pkg::link_st_e st;
    flash_regs_pkg::link_st_e after;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic oe;
    logic wr_tgl;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic req;
    logic [15:0] snap;
  } link_s;
  link_s l_r, l_nxt;

  logic [2:0] link_in;
  logic scl_s;
  logic sda_s;
  logic ack_s;
  logic snap_ack;
  logic [15:0] core_snap;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] rd_byte;

  cdc_sync #(.W(3)) u_link_sync (
    .i_clk(i_link_clk),
    .i_rstn(rstn_link),
    .i_d({i_scl, i_sda, snap_ack}),
    .o_q(link_in)
  );
  assign scl_s = link_in[2];
  assign sda_s = link_in[1];
  assign ack_s = link_in[0];

  // bus events from synchronised pins
  assign scl_rise = scl_s & ~l_r.scl_d;
  assign scl_fall = ~scl_s & l_r.scl_d;
  assign start_seen = scl_s & l_r.scl_d & l_r.sda_d & ~sda_s;
  assign stop_seen = scl_s & l_r.scl_d & ~l_r.sda_d & sda_s;

  // byte returned for the held pointer, unmapped reads zero
  always_comb begin
    if (l_r.ptr == flash_regs_pkg::SINK_CONTROL_ADDR) begin
      rd_byte = l_r.snap[15:8];
    end else if (l_r.ptr == flash_regs_pkg::REGULATOR_CONTROL_ADDR) begin
      rd_byte = l_r.snap[7:0];
    end else begin
      rd_byte = 8'h00;
    end
  end

  // serial slave engine
  always_comb begin
    l_nxt = l_r;
    l_nxt.scl_d = scl_s;
    l_nxt.sda_d = sda_s;
    // refresh the register snapshot by request/acknowledge
    if (ack_s == l_r.req) begin
      l_nxt.snap = core_snap;
      l_nxt.req = ~l_r.req;
    end
    if (start_seen) begin
      // plain or repeated start both restart address phase
      l_nxt.st = flash_regs_pkg::ST_ADDR;
      l_nxt.cnt = 4'h0;
      l_nxt.oe = 1'b0;
    end else if (stop_seen) begin
      l_nxt.st = flash_regs_pkg::ST_IDLE;
      l_nxt.oe = 1'b0;
    end else begin
      case (l_r.st)
        flash_regs_pkg::ST_ADDR,
        flash_regs_pkg::ST_REG,
        flash_regs_pkg::ST_WR: begin
          if (scl_rise && l_r.cnt != 4'h8) begin
            l_nxt.sh = {l_r.sh[6:0], sda_s};
            l_nxt.cnt = l_r.cnt + 4'h1;
          end else if (scl_fall && l_r.cnt == 4'h8) begin
            l_nxt.cnt = 4'h0;
            l_nxt.oe = 1'b1;
            l_nxt.st = flash_regs_pkg::ST_ACK;
            if (l_r.st == flash_regs_pkg::ST_ADDR) begin
              if (l_r.sh[7:1] == flash_regs_pkg::SLAVE_ADDR) begin
                l_nxt.after = l_r.sh[0] ? flash_regs_pkg::ST_RD : flash_regs_pkg::ST_REG;
              end else begin
                l_nxt.oe = 1'b0;
                l_nxt.st = flash_regs_pkg::ST_IDLE;
              end
            end else if (l_r.st == flash_regs_pkg::ST_REG) begin
              l_nxt.ptr = l_r.sh;
              l_nxt.after = flash_regs_pkg::ST_WR;
            end else begin
              // data byte: hand over, pointer stays put
              l_nxt.wr_addr = l_r.ptr;
              l_nxt.wr_data = l_r.sh;
              l_nxt.wr_tgl = ~l_r.wr_tgl;
              l_nxt.after = flash_regs_pkg::ST_WR;
            end
          end
        end
        flash_regs_pkg::ST_ACK: begin
          if (scl_fall) begin
            l_nxt.oe = 1'b0;
            l_nxt.cnt = 4'h0;
            l_nxt.st = l_r.after;
            if (l_r.after == flash_regs_pkg::ST_RD) begin
              // first data bit driven right after the ack
              l_nxt.oe = ~rd_byte[7];
              l_nxt.tx = {rd_byte[6:0], 1'b0};
              l_nxt.cnt = 4'h1;
            end
          end
        end
        flash_regs_pkg::ST_RD: begin
          if (scl_fall) begin
            if (l_r.cnt == 4'h8) begin
              l_nxt.oe = 1'b0;
              l_nxt.cnt = 4'h0;
              l_nxt.st = flash_regs_pkg::ST_MACK;
            end else begin
              l_nxt.oe = ~l_r.tx[7];
              l_nxt.tx = {l_r.tx[6:0], 1'b0};
              l_nxt.cnt = l_r.cnt + 4'h1;
            end
          end
        end
        flash_regs_pkg::ST_MACK: begin
          // nack ends the read, ack repeats the same register
          if (scl_rise) begin
            l_nxt.st = sda_s ? flash_regs_pkg::ST_IDLE : flash_regs_pkg::ST_ACK;
            l_nxt.after = flash_regs_pkg::ST_RD;
          end
        end
        default: begin
          l_nxt.st = flash_regs_pkg::ST_IDLE;
          l_nxt.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_link_clk or negedge rstn_link) begin
    if (!rstn_link) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // open-drain pin: only ever pulled low
  assign o_sda = 1'b0;
  assign o_sda_oe = l_r.oe;

  // ---- core domain
  typedef struct packed {
    logic [7:0] sink_ctl;
    logic [7:0] reg_ctl;
    logic wr_last;
    logic ack;
    logic [15:0] snap;
    logic sink_on;
    logic [8:0] cur_ma;
    logic [11:0] a_mv;
    logic [11:0] b_mv;
  } core_s;
  core_s c_r, c_nxt;

  logic [3:0] core_in;
  logic wr_s;
  logic req_s;
  logic en_s;
  logic trig_s;
  logic wr_evt;
  logic [2:0] code;
  logic [2:0] b_code;
  logic [3:0] a_code;
  logic demand;
  logic rearm;
  logic expired;

  cdc_sync #(.W(4)) u_core_sync (
    .i_clk(i_clk),
    .i_rstn(rstn_core),
    .i_d({l_r.wr_tgl, l_r.req, i_chip_enable, i_flash_trigger_pin}),
    .o_q(core_in)
  );
  assign wr_s = core_in[3];
  assign req_s = core_in[2];
  assign en_s = core_in[1];
  assign trig_s = core_in[0];

  assign wr_evt = wr_s != c_r.wr_last;
  assign code = c_r.sink_ctl[flash_regs_pkg::CODE_LSB +: 3];
  assign b_code = c_r.reg_ctl[flash_regs_pkg::REG_B_LSB +: 3];
  assign a_code = c_r.reg_ctl[flash_regs_pkg::REG_A_LSB +: 4];

  // sink wanted: trigger high and a nonzero code
  assign demand = trig_s & (code != 3'h0);
  // re-arm by trigger low, or code written nonzero from zero
  assign rearm = ~trig_s
    | (en_s & wr_evt & (l_r.wr_addr == flash_regs_pkg::SINK_CONTROL_ADDR)
       & (code == 3'h0) & (l_r.wr_data[flash_regs_pkg::CODE_LSB +: 3] != 3'h0));

  sink_timeout #(.CYCLES(TIMEOUT_CYCLES)) u_timeout (
    .i_clk(i_clk),
    .i_rstn(rstn_core),
    .i_demand(demand),
    .i_enable(c_r.sink_ctl[flash_regs_pkg::TIMEOUT_EN_BIT]),
    .i_rearm(rearm),
    .o_expired(expired)
  );

  // register file, decoders and snapshot
  always_comb begin
    c_nxt = c_r;
    c_nxt.wr_last = wr_s;
    if (!en_s) begin
      c_nxt.sink_ctl = flash_regs_pkg::SINK_CONTROL_RESET;
      c_nxt.reg_ctl = flash_regs_pkg::REGULATOR_CONTROL_RESET;
    end else if (wr_evt) begin
      // full 8-bit registers; unmapped addresses fall through
      if (l_r.wr_addr == flash_regs_pkg::SINK_CONTROL_ADDR) begin
        c_nxt.sink_ctl = l_r.wr_data;
      end else if (l_r.wr_addr == flash_regs_pkg::REGULATOR_CONTROL_ADDR) begin
        c_nxt.reg_ctl = l_r.wr_data;
      end
    end
    // answer a snapshot request with current contents
    if (req_s != c_r.ack) begin
      c_nxt.snap = {c_r.sink_ctl, c_r.reg_ctl};
      c_nxt.ack = req_s;
    end
    c_nxt.sink_on = demand & ~expired;
    // sink current by range and code
    if (code == 3'h0) begin
      c_nxt.cur_ma = 9'h000;
    end else if (c_r.sink_ctl[flash_regs_pkg::RANGE_BIT]) begin
      if (code == 3'h1) begin
        c_nxt.cur_ma = flash_regs_pkg::FLASH_LOW_MA;
      end else if (code == 3'h2) begin
        c_nxt.cur_ma = flash_regs_pkg::FLASH_MID_MA;
      end else begin
        c_nxt.cur_ma = flash_regs_pkg::FLASH_MAX_MA;
      end
    end else if (code > 3'h4) begin
      c_nxt.cur_ma = flash_regs_pkg::SPOT_MAX_MA;
    end else begin
      c_nxt.cur_ma = 9'(flash_regs_pkg::CUR_STEP_MA * {6'h00, code});
    end
    // regulator A, unused codes off
    if (a_code == 4'h0 || a_code > flash_regs_pkg::REG_A_MAX_CODE) begin
      c_nxt.a_mv = 12'h000;
    end else begin
      c_nxt.a_mv = 12'(flash_regs_pkg::REG_A_TOP_MV + flash_regs_pkg::REG_STEP_MV
        - flash_regs_pkg::REG_STEP_MV * {8'h00, a_code});
    end
    // regulator B, upper codes off
    if (b_code == 3'h0 || b_code > flash_regs_pkg::REG_B_MAX_CODE) begin
      c_nxt.b_mv = 12'h000;
    end else begin
      c_nxt.b_mv = 12'(flash_regs_pkg::REG_B_TOP_MV + flash_regs_pkg::REG_STEP_MV
        - flash_regs_pkg::REG_STEP_MV * {9'h000, b_code});
    end
  end

  always_ff @(posedge i_clk or negedge rstn_core) begin
    if (!rstn_core) begin
      c_r <= '0;
      c_r.sink_ctl <= flash_regs_pkg::SINK_CONTROL_RESET;
      c_r.reg_ctl <= flash_regs_pkg::REGULATOR_CONTROL_RESET;
    end else begin
      c_r <= c_nxt;
    end
  end

  // outputs
  assign snap_ack = c_r.ack;
  assign core_snap = c_r.snap;
  assign o_sink_on = c_r.sink_on;
  assign o_sink_current_ma = c_r.sink_on ? c_r.cur_ma : 9'h000;
  assign o_safety_timed_out = expired;
  assign o_regulator_a_mv = c_r.a_mv;
  assign o_regulator_b_mv = c_r.b_mv;
  assign o_sink_control = c_r.sink_ctl;
  assign o_regulator_control = c_r.reg_ctl;
endmodule // flash_regulator_control_regs
`default_nettype wire

//--- core/sink_timeout.sv
// safety timer for the current sink
// assumes synchronous inputs on the core clock
`timescale 1ns/1ps
`default_nettype none
module sink_timeout #(
  parameter int CYCLES = flash_regs_pkg::TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // control
  input wire logic i_demand,
  input wire logic i_enable,
  input wire logic i_rearm,
  // status
  output logic o_expired
);
  typedef struct packed {
    logic [31:0] cnt;
    logic expired;
  } tmo_s;
  tmo_s r, r_nxt;
  logic hit;

  // count while the sink is on, hold off once expired
  always_comb begin
    r_nxt = r;
    hit = 1'b0;
    if (!i_demand || !i_enable || r.expired) begin
      r_nxt.cnt = '0;
    end else if (r.cnt == 32'(CYCLES - 1)) begin
      hit = 1'b1;
      r_nxt.cnt = '0;
    end else begin
      r_nxt.cnt = r.cnt + 32'h1;
    end
    // expiry wins over a re-arm in the same cycle
    r_nxt.expired = (r.expired & ~i_rearm) | hit;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign o_expired = r.expired;
endmodule // sink_timeout
`default_nettype wire

//--- tb/flash_regs_chk.sv
// assertions on the register bank's sink, timer and regulator outputs
// assumes binding into the top module, one core clock domain
`timescale 1ns/1ps
`default_nettype none
module flash_regs_chk #(
  parameter int TIMEOUT_CYCLES = 1000
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // device pins
  input wire logic i_chip_enable,
  input wire logic i_flash_trigger_pin,
  // outputs watched
  input wire logic o_sink_on,
  input wire logic [8:0] o_sink_current_ma,
  input wire logic o_safety_timed_out,
  input wire logic [11:0] o_regulator_a_mv,
  input wire logic [11:0] o_regulator_b_mv,
  input wire logic [7:0] o_sink_control,
  input wire logic [7:0] o_regulator_control
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  int unsigned run_r;
  // expected sink current from register contents
  function automatic logic [8:0] ema(input logic [7:0] v);
    logic [2:0] c;
    c = v[3:1];
    if (c == 3'h0) return 9'h000;
    if (v[0]) return c > 3'h2 ? 9'h190 : 9'h0fa + 9'h032 * c;
    return c > 3'h4 ? 9'h0fa : 9'h032 * c;
  endfunction
  // expected regulator voltage, a selects the four-bit field
  function automatic logic [11:0] emv(input logic [3:0] c, input logic a);
    if (c == 4'h0 || c > (a ? 4'h9 : 4'h4)) return 12'h000;
    return (a ? 12'hd48 : 12'h76c) - 12'h064 * c;
  endfunction
  // cycles the sink has run with the timer armed
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) run_r <= 0;
    else run_r <= (o_sink_on && o_sink_control[4]) ? run_r + 1 : 0;
  end
  sequence s_trig_low;
    !i_flash_trigger_pin [*6];
  endsequence
  sequence s_en_low;
    !i_chip_enable [*6];
  endsequence
  property p_off_zero;
    !o_sink_on |-> o_sink_current_ma == 9'h000;
  endproperty
  property p_needs_code;
    o_sink_on |-> $past(o_sink_control[3:1]) != 3'h0;
  endproperty
  property p_cur_map;
    o_sink_on && $stable(o_sink_control) |-> o_sink_current_ma == ema(o_sink_control);
  endproperty
  property p_reg_a;
    $stable(o_regulator_control) && o_regulator_control[3:0] <= 4'h9
      |-> o_regulator_a_mv == emv(o_regulator_control[3:0], 1'b1);
  endproperty
  property p_reg_b;
    $stable(o_regulator_control) |-> o_regulator_b_mv == emv({1'b0, o_regulator_control[6:4]}, 1'b0);
  endproperty
  property p_to_off;
    o_safety_timed_out [*2] |-> !o_sink_on;
  endproperty
  property p_timer_len;
    run_r <= TIMEOUT_CYCLES + 4;
  endproperty
  property p_trig_rearm;
    s_trig_low |-> !o_safety_timed_out;
  endproperty
  property p_trig_off;
    s_trig_low |-> !o_sink_on;
  endproperty
  property p_en_defaults;
    s_en_low |-> o_sink_control == 8'h10 && o_regulator_control == 8'h00;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("current while sink off");
  a_needs_code: assert property (p_needs_code) else $error("sink on with code zero");
  a_cur_map: assert property (p_cur_map) else $error("sink current decode wrong");
  a_reg_a: assert property (p_reg_a) else $error("regulator a decode wrong");
  a_reg_b: assert property (p_reg_b) else $error("regulator b decode wrong");
  a_to_off: assert property (p_to_off) else $error("sink on after expiry");
  a_timer_len: assert property (p_timer_len) else $error("timer ran too long");
  a_trig_rearm: assert property (p_trig_rearm) else $error("pin low kept expiry");
  a_trig_off: assert property (p_trig_off) else $error("sink on with pin low");
  a_en_defaults: assert property (p_en_defaults) else $error("enable low kept values");
endmodule // flash_regs_chk
bind flash_regulator_control_regs flash_regs_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_flash_regs_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_chip_enable(i_chip_enable),
  .i_flash_trigger_pin(i_flash_trigger_pin), .o_sink_on(o_sink_on),
  .o_sink_current_ma(o_sink_current_ma), .o_safety_timed_out(o_safety_timed_out),
  .o_regulator_a_mv(o_regulator_a_mv), .o_regulator_b_mv(o_regulator_b_mv),
  .o_sink_control(o_sink_control), .o_regulator_control(o_regulator_control));
`default_nettype wire

//--- tb/flash_regulator_control_regs_tb.sv
// self-checking bench for the flash and regulator register bank
// assumes the host model on the serial pins and a pull-up on sda
`timescale 1ns/1ps
`default_nettype none
module flash_regulator_control_regs_tb;
  localparam int TO = 2000;
  localparam logic [6:0] SA = flash_regs_pkg::SLAVE_ADDR;
  logic i_clk, i_rstn, i_link_clk, i_chip_enable, i_flash_trigger_pin, scl, pull;
  logic o_sda, o_sda_oe, o_sink_on, o_safety_timed_out;
  logic [8:0] o_sink_current_ma;
  logic [11:0] o_regulator_a_mv, o_regulator_b_mv;
  logic [7:0] o_sink_control, o_regulator_control;
  wire logic sda;
  int n_fail = 0;
  int checked = 0;
  // open-drain wire with pull-up
  assign sda = !(pull || o_sda_oe);
  // core clock, 5 ns
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // link clock, 12 ns, offset phase
  initial begin
    i_link_clk = 1'b0;
    #3.7;
    forever #6 i_link_clk = ~i_link_clk;
  end
  flash_regulator_control_regs #(.TIMEOUT_CYCLES(TO)) u_flash_regulator_control_regs (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_link_clk(i_link_clk), .i_scl(scl), .i_sda(sda),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_chip_enable(i_chip_enable),
    .i_flash_trigger_pin(i_flash_trigger_pin), .o_sink_on(o_sink_on),
    .o_sink_current_ma(o_sink_current_ma), .o_safety_timed_out(o_safety_timed_out),
    .o_regulator_a_mv(o_regulator_a_mv), .o_regulator_b_mv(o_regulator_b_mv),
    .o_sink_control(o_sink_control), .o_regulator_control(o_regulator_control));
  i2c_host_model u_i2c_host_model (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
  // verdict and end of run
  task automatic end_sim();
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // value compare
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t %s", $time, m);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // expected sink current
  function automatic logic [8:0] ema(input logic [7:0] v);
    logic [2:0] c;
    c = v[3:1];
    if (c == 3'h0) return 9'h000;
    if (v[0]) return c > 3'h2 ? 9'h190 : 9'h0fa + 9'h032 * c;
    return c > 3'h4 ? 9'h0fa : 9'h032 * c;
  endfunction
  // expected regulator voltage, a selects the four-bit field
  function automatic logic [11:0] emv(input logic [3:0] c, input logic a);
    if (c == 4'h0 || c > (a ? 4'h9 : 4'h4)) return 12'h000;
    return (a ? 12'hd48 : 12'h76c) - 12'h064 * c;
  endfunction
  // values after reset
  task automatic t_reset();
    cmp({o_sink_control, o_regulator_control}, 16'h1000, "reset regs");
    cmp(16'({o_sda, o_sda_oe, o_sink_on, o_safety_timed_out, o_regulator_a_mv}), 16'h0000, "reset outs");
    cmp(16'(o_regulator_b_mv), 16'h0000, "reset reg b");
  endtask
  // regulator codes written, decoded, read back both ways
  task automatic t_regs();
    logic [7:0] v[4] = '{8'h19, 8'h41, 8'h50, 8'h34};
    logic [2:0] a;
    logic [7:0] d;
    foreach (v[i]) begin
      u_i2c_host_model.wr(SA, 8'h03, v[i], a);
      w(10);
      cmp(16'(a), 16'h0000, "reg ack");
      cmp(16'(o_regulator_control), 16'(v[i]), "reg value");
      cmp(16'(o_regulator_a_mv), 16'(emv(v[i][3:0], 1'b1)), "reg a mv");
      cmp(16'(o_regulator_b_mv), 16'(emv({1'b0, v[i][6:4]}, 1'b0)), "reg b mv");
      u_i2c_host_model.rd(8'h03, i[0], d);
      cmp(16'(d), 16'(v[i]), "reg read");
    end
  endtask
  // every code in both ranges, timer off
  task automatic t_map();
    logic [2:0] a;
    logic [7:0] v;
    i_flash_trigger_pin = 1'b1;
    for (int k = 0; k < 16; k++) begin
      v = {4'h0, k[2:0], k[3]};
      u_i2c_host_model.wr(SA, 8'h02, v, a);
      w(10);
      cmp(16'(o_sink_on), 16'(k[2:0] != 0), "sink on");
      cmp(16'(o_sink_current_ma), 16'(ema(v)), "sink ma");
    end
  endtask
  // expiry, pin re-arm, write re-arm
  task automatic t_timer();
    logic [2:0] a;
    u_i2c_host_model.wr(SA, 8'h02, 8'h12, a);
    w(TO - 400);
    cmp(16'(o_safety_timed_out), 16'h0000, "early expiry");
    w(600);
    cmp(16'({o_safety_timed_out, o_sink_on}), 16'h0002, "expiry");
    i_flash_trigger_pin = 1'b0;
    w(10);
    cmp(16'(o_safety_timed_out), 16'h0000, "pin rearm");
    i_flash_trigger_pin = 1'b1;
    w(TO + 30);
    cmp(16'(o_safety_timed_out), 16'h0001, "second expiry");
    u_i2c_host_model.wr(SA, 8'h02, 8'h10, a);
    u_i2c_host_model.wr(SA, 8'h02, 8'h12, a);
    w(10);
    cmp(16'({o_safety_timed_out, o_sink_on}), 16'h0001, "write rearm");
    u_i2c_host_model.wr(SA, 8'h02, 8'h10, a);
  endtask
  // write and read of an unmapped register
  task automatic t_unmapped();
    logic [2:0] a;
    logic [7:0] d;
    u_i2c_host_model.wr(SA, 8'h05, 8'h5a, a);
    w(10);
    cmp(16'(a), 16'h0000, "unmapped ack");
    cmp({o_sink_control, o_regulator_control}, 16'h1034, "unmapped kept");
    u_i2c_host_model.rd(8'h05, 1'b1, d);
    cmp(16'(d), 16'h0000, "unmapped read");
  endtask
  // another slave address is ignored
  task automatic t_addr();
    logic [2:0] a;
    u_i2c_host_model.wr(7'h38, 8'h03, 8'h7f, a);
    w(10);
    cmp(16'(a[2]), 16'h0001, "addr nack");
    cmp(16'(o_regulator_control), 16'h0034, "addr kept");
  endtask
  // chip enable low restores defaults
  task automatic t_enable();
    logic [2:0] a;
    u_i2c_host_model.wr(SA, 8'h02, 8'h0e, a);
    i_chip_enable = 1'b0;
    w(10);
    cmp({o_sink_control, o_regulator_control}, 16'h1000, "enable defaults");
    i_chip_enable = 1'b1;
    w(10);
  endtask
  // reset then scenarios
  initial begin
    i_rstn = 1'b0;
    i_chip_enable = 1'b1;
    i_flash_trigger_pin = 1'b0;
    repeat (16) @(negedge i_clk);
    i_rstn = 1'b1;
    w(40);
    t_reset();
    t_regs();
    t_map();
    t_timer();
    t_unmapped();
    t_addr();
    t_enable();
    end_sim();
  end
  // watchdog over the expected run length
  initial begin
    #480us;
    n_fail++;
    end_sim();
  end
endmodule // flash_regulator_control_regs_tb
`default_nettype wire

//--- tb/i2c_host_model.sv
// two-wire bus master: drives scl, pulls sda low, reads the wire
// assumes a pull-up on sda; steps timed off the core clock
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
  parameter int Q = 20
) (
  // timing and wire
  input wire logic i_clk,
  input wire logic i_sda,
  // pins driven
  output logic o_scl,
  output logic o_sda_pull
);
  // idle bus, clock stands high
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end
  // quarter bit time
  task automatic q();
    repeat (Q) @(negedge i_clk);
  endtask
  // start or repeated start, scl left low
  task automatic start();
    o_sda_pull = 1'b0;
    q();
    o_scl = 1'b1;
    q();
    o_sda_pull = 1'b1;
    q();
    o_scl = 1'b0;
  endtask
  // stop, bus left idle
  task automatic stop();
    q();
    o_sda_pull = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    o_sda_pull = 1'b0;
    q();
  endtask
  // one bit out, wire sampled while scl high
  task automatic bit_io(input logic b, output logic r);
    q();
    o_sda_pull = !b;
    q();
    o_scl = 1'b1;
    q();
    r = i_sda;
    q();
    o_scl = 1'b0;
  endtask
  // byte msb first, ack slot released
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, ack);
  endtask
  // direct write, ack bits returned, zero means acked
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d, output logic [2:0] a);
    logic [7:0] x;
    start();
    xfer({dev, 1'b0}, x, a[2]);
    xfer(ra, x, a[1]);
    xfer(d, x, a[0]);
    stop();
  endtask
  // read: combined when sr set, else stop-separated
  task automatic rd(input logic [7:0] ra, input logic sr, output logic [7:0] d);
    logic a;
    start();
    xfer({flash_regs_pkg::SLAVE_ADDR, 1'b0}, d, a);
    xfer(ra, d, a);
    if (!sr) stop();
    start();
    xfer({flash_regs_pkg::SLAVE_ADDR, 1'b1}, d, a);
    xfer(8'hff, d, a);
    stop();
  endtask
endmodule // i2c_host_model
`default_nettype wire
